// ===== hw/sifm_mapper.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sifm_mapper
	import sifm_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset,
	// digital inputs, already assigned to functions
	input  wire sifm_din_t         din,
	input  wire logic [POS_W-1:0]  act_pos,
	// register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// drive actions
	output logic      [CW_W-1:0]   ctrl_word,
	output logic      [7:0]        op_mode,
	output logic                   drive_enabled,
	output logic                   cmd_trigger,
	output logic                   ext_fault,
	output logic                   pulse_flush,
	output logic                   trim_pos_step,
	output logic                   trim_neg_step,
	output logic                   block_pos,
	output logic                   block_neg,
	output logic      [2:0]        gear_idx,
	output logic      [1:0]        gain_ptr,
	output logic      [2:0]        target_idx
);

////////////////////////////////////////////////////////////////////////////
	sifm_din_t s1_q, s2_q, s3_q;
	always_ff @(posedge clk_sys) begin
		// idle levels, so leaving reset fakes neither a quick stop nor an edge
		if (reset) begin
			s1_q <= DIN_IDLE;
			s2_q <= DIN_IDLE;
			s3_q <= DIN_IDLE;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	sifm_din_t d;
	assign d = s2_q;
	logic en_rise, home_rise, act_rise;
	assign en_rise   = d.enable & ~s3_q.enable;
	assign home_rise = d.start_home & ~s3_q.start_home;
	assign act_rise  = d.activate & ~s3_q.activate;

////////////////////////////////////////////////////////////////////////////
	logic [7:0]      ctrl_q, ctrl_d;
	logic [CW_W-1:0] en_cw_q, en_cw_d;
	logic [7:0]      mode_q, mode_d, saved_q, saved_d;
	logic            homing_q, homing_d;
	logic            qs_latch_q, qs_latch_d;
	logic            arm_d;
	logic [CW_W-1:0] cw_q, cw_d;
	logic            en_q, en_d, trig_q, trig_d;
	logic [CW_W-1:0] sw_cw_q, sw_cw_d;

	always_comb begin
		ctrl_d     = ctrl_q;
		en_cw_d    = en_cw_q;
		mode_d     = mode_q;
		saved_d    = saved_q;
		homing_d   = homing_q;
		qs_latch_d = qs_latch_q;
		arm_d      = 1'b0;
		trig_d     = 1'b0;
		sw_cw_d    = sw_cw_q;
		if (reg_wr) begin
			unique case (reg_addr)
				A_CTRL:  ctrl_d  = reg_wdata[7:0];
				A_EN_CW: en_cw_d = reg_wdata[CW_W-1:0];
				A_MODE:  mode_d  = reg_wdata[7:0];
				A_CW:    sw_cw_d = reg_wdata[CW_W-1:0];
				default: ;
			endcase
		end
		// software path: quick-stop latch cleared by 0x06 then 0x0f
		if (reg_wr && reg_addr == A_CW && qs_latch_q &&
				reg_wdata[CW_W-1:0] == CW_OPER && sw_cw_q == CW_SHUT)
			qs_latch_d = 1'b0;
		if (en_rise)
			qs_latch_d = 1'b0;
		if (!d.quick_stop_n)
			qs_latch_d = 1'b1;
		if (home_rise && en_q && !homing_q) begin
			saved_d  = mode_q;
			mode_d   = MODE_HOME;
			homing_d = 1'b1;
		end else if (homing_q && d.home_found) begin
			mode_d   = saved_q;
			homing_d = 1'b0;
		end
		if (act_rise)
			trig_d = 1'b1;
		arm_d = act_rise;

		en_d = d.enable & d.pre_enable & ~qs_latch_d;
		if (d.enable && d.pre_enable)
			cw_d = en_cw_q;
		else
			cw_d = CW_SHUT;
		// command patterns only while enabled, so they never lift a stop
		if (en_d) begin
			if (arm_d)
				cw_d = (cw_d & ~CW_GO) | CW_GO;
			else if (d.activate)
				cw_d = (cw_d & ~CW_GO) | CW_ARM;
		end
		if (qs_latch_d)
			cw_d[CW_QSTOP] = 1'b0;
		if (d.err_reset)
			cw_d[CW_RSTERR] = 1'b1;
		if (d.pause)
			cw_d[CW_HALT] = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_q     <= 8'h00;
			en_cw_q    <= CW_OPER;
			mode_q     <= MODE_RST;
			saved_q    <= MODE_RST;
			homing_q   <= 1'b0;
			qs_latch_q <= 1'b0;
			cw_q       <= CW_SHUT;
			en_q       <= 1'b0;
			trig_q     <= 1'b0;
			sw_cw_q    <= 16'h0000;
		end else begin
			ctrl_q     <= ctrl_d;
			en_cw_q    <= en_cw_d;
			mode_q     <= mode_d;
			saved_q    <= saved_d;
			homing_q   <= homing_d;
			qs_latch_q <= qs_latch_d;
			cw_q       <= cw_d;
			en_q       <= en_d;
			trig_q     <= trig_d;
			sw_cw_q    <= sw_cw_d;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// plain routing; registered so every output leaves a flip-flop
	logic       flt_q, flush_q, tp_q, tn_q, bp_q, bn_q;
	logic [2:0] gear_q, tidx_q;
	logic [1:0] gain_q;
	logic       flt_d, flush_d, tp_d, tn_d, bp_d, bn_d;
	logic [2:0] gear_d, tidx_d;
	logic [1:0] gain_d;
	always_comb begin
		flt_d   = d.motor_err;
		flush_d = d.clear_pulse;
		tp_d    = d.trim_pos & ctrl_q[C_PULSEMD];
		tn_d    = d.trim_neg & ctrl_q[C_PULSEMD];
		bp_d    = ~d.lim_pos;
		bn_d    = ~d.lim_neg;
		gear_d  = {d.multi[2], d.multi[1], d.multi[0]};
		gain_d  = {d.gain[1], d.gain[0]};
		// holds last entry outside digital-input position mode
		tidx_d  = ctrl_q[C_DINMODE] ? d.pos_idx : tidx_q;
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flt_q   <= 1'b0;
			flush_q <= 1'b0;
			tp_q    <= 1'b0;
			tn_q    <= 1'b0;
			bp_q    <= 1'b1;
			bn_q    <= 1'b1;
			gear_q  <= 3'h0;
			gain_q  <= 2'h0;
			tidx_q  <= 3'h0;
		end else begin
			flt_q   <= flt_d;
			flush_q <= flush_d;
			tp_q    <= tp_d;
			tn_q    <= tn_d;
			bp_q    <= bp_d;
			bn_q    <= bn_d;
			gear_q  <= gear_d;
			gain_q  <= gain_d;
			tidx_q  <= tidx_d;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// capture: flag[2c] rising, flag[2c+1] falling; latency 3 cycles,
	// far inside the 2 ms response bound
	logic [2*NCAP-1:0] flg_q, flg_d;
	logic [POS_W-1:0]  cpos_q [2*NCAP];
	logic [POS_W-1:0]  cpos_d [2*NCAP];
	genvar c;
	generate
		for (c = 0; c < NCAP; c++) begin : g_cap
			logic rise, fall, clr_r, clr_f;
			assign rise = d.cap[c] & ~s3_q.cap[c] & ctrl_q[C_CAPRISE+c];
			assign fall = ~d.cap[c] & s3_q.cap[c] & ctrl_q[C_CAPFALL+c];
			assign clr_r = reg_wr && reg_addr == A_CAPFLG && !reg_wdata[2*c];
			assign clr_f = reg_wr && reg_addr == A_CAPFLG
				&& !reg_wdata[2*c+1];
			always_comb begin
				flg_d[2*c]    = flg_q[2*c];
				flg_d[2*c+1]  = flg_q[2*c+1];
				cpos_d[2*c]   = cpos_q[2*c];
				cpos_d[2*c+1] = cpos_q[2*c+1];
				if (clr_r)
					flg_d[2*c] = 1'b0;
				if (clr_f)
					flg_d[2*c+1] = 1'b0;
				// a clear wins over an edge in the same cycle while the flag is set; that edge is lost
				if (rise && !flg_q[2*c]) begin
					flg_d[2*c]  = 1'b1;
					cpos_d[2*c] = act_pos;
				end
				if (fall && !flg_q[2*c+1]) begin
					flg_d[2*c+1]  = 1'b1;
					cpos_d[2*c+1] = act_pos;
				end
			end
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					flg_q[2*c]    <= 1'b0;
					flg_q[2*c+1]  <= 1'b0;
					cpos_q[2*c]   <= '0;
					cpos_q[2*c+1] <= '0;
				end else begin
					flg_q[2*c]    <= flg_d[2*c];
					flg_q[2*c+1]  <= flg_d[2*c+1];
					cpos_q[2*c]   <= cpos_d[2*c];
					cpos_q[2*c+1] <= cpos_d[2*c+1];
				end
			end
			a_cap_hold: assert property (
				@(posedge clk_sys) disable iff (reset)
				flg_q[2*c] && !clr_r |=> $stable(cpos_q[2*c])
			) else $error("rising capture overwritten while flagged");
			a_cap_take: assert property (
				@(posedge clk_sys) disable iff (reset)
				rise && !flg_q[2*c] |=>
				flg_q[2*c] && cpos_q[2*c] == $past(act_pos)
			) else $error("rising capture missed");
			a_fall_take: assert property (
				@(posedge clk_sys) disable iff (reset)
				fall && !flg_q[2*c+1] |=> flg_q[2*c+1]
			) else $error("falling capture missed");
			a_fall_pos: assert property (
				@(posedge clk_sys) disable iff (reset)
				fall && !flg_q[2*c+1] |=> cpos_q[2*c+1] == $past(act_pos)
			) else $error("falling capture position wrong");
			a_fall_hold: assert property (
				@(posedge clk_sys) disable iff (reset)
				flg_q[2*c+1] && !clr_f |=> $stable(cpos_q[2*c+1])
			) else $error("falling capture overwritten while flagged");
			a_flag_clear: assert property (
				@(posedge clk_sys) disable iff (reset)
				clr_r && !rise |=> !flg_q[2*c]
			) else $error("rising flag not cleared by zero write");
		end
	endgenerate

////////////////////////////////////////////////////////////////////////////
	logic [31:0] rd_q, rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				A_CTRL:   rd_d = {24'h0, ctrl_q};
				A_STATUS: rd_d = {26'h0, flt_q, homing_q, qs_latch_q, en_q,
					bp_q, bn_q};
				A_CAPFLG: rd_d = {28'h0, flg_q};
				A_EN_CW:  rd_d = {16'h0, en_cw_q};
				A_MODE:   rd_d = {24'h0, mode_q};
				A_CW:     rd_d = {16'h0, cw_q};
				4'h8, 4'h9, 4'ha, 4'hb:
					rd_d = cpos_q[reg_addr[1:0]];
				default:  rd_d = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset)
			rd_q <= 32'h0000_0000;
		else
			rd_q <= rd_d;
	end

	assign reg_rdata     = rd_q;
	assign ctrl_word     = cw_q;
	assign op_mode       = mode_q;
	assign drive_enabled = en_q;
	assign cmd_trigger   = trig_q;
	assign ext_fault     = flt_q;
	assign pulse_flush   = flush_q;
	assign trim_pos_step = tp_q;
	assign trim_neg_step = tn_q;
	assign block_pos     = bp_q;
	assign block_neg     = bn_q;
	assign gear_idx      = gear_q;
	assign gain_ptr      = gain_q;
	assign target_idx    = tidx_q;

////////////////////////////////////////////////////////////////////////////
	a_qstop_bit: assert property (
		@(posedge clk_sys) disable iff (reset)
		!d.quick_stop_n |=> !cw_q[CW_QSTOP] && !en_q
	) else $error("quick stop did not clear bit 2");
	a_en_restart: assert property (
		@(posedge clk_sys) disable iff (reset)
		qs_latch_q && en_rise && d.quick_stop_n |=> !qs_latch_q
	) else $error("enable edge did not release quick stop");
	a_home_gate: assert property (
		@(posedge clk_sys) disable iff (reset)
		home_rise && !en_q && !homing_q |=> !homing_q
	) else $error("homing started while disabled");
	a_home_start: assert property (
		@(posedge clk_sys) disable iff (reset)
		home_rise && en_q && !homing_q |=> homing_q && op_mode == MODE_HOME
	) else $error("homing did not start while enabled");
	a_home_back: assert property (
		@(posedge clk_sys) disable iff (reset)
		homing_q && d.home_found |=> !homing_q && mode_q == $past(saved_q)
	) else $error("mode not restored after homing");
	a_act_go: assert property (
		@(posedge clk_sys) disable iff (reset)
		act_rise |=> (cmd_trigger &&
		((ctrl_word[5:0] == CW_GO[5:0]) == drive_enabled)) ##1 !cmd_trigger
	) else $error("activate did not pulse");
	a_pre_gate: assert property (
		@(posedge clk_sys) disable iff (reset)
		!d.pre_enable |=> !drive_enabled && ctrl_word[3:0] != CW_OPER[3:0]
	) else $error("enabled without pre-enable");
	a_en_word: assert property (
		@(posedge clk_sys) disable iff (reset)
		!d.enable && d.quick_stop_n && !qs_latch_q |=>
		ctrl_word[5:0] == CW_SHUT[5:0]
	) else $error("control word not forced to shutdown");
	a_err_bit: assert property (
		@(posedge clk_sys) disable iff (reset)
		d.err_reset |=> ctrl_word[CW_RSTERR]
	) else $error("error reset bit missing");
	a_pause_bit: assert property (
		@(posedge clk_sys) disable iff (reset)
		d.pause |=> ctrl_word[CW_HALT]
	) else $error("pause bit missing");
	a_gear_idx: assert property (
		@(posedge clk_sys) disable iff (reset)
		1'b1 |=> gear_idx == $past(d.multi)
	) else $error("gear index wrong");
	a_gain_ptr: assert property (
		@(posedge clk_sys) disable iff (reset)
		1'b1 |=> gain_ptr == $past(d.gain)
	) else $error("gain pointer wrong");
	a_fault_lvl: assert property (
		@(posedge clk_sys) disable iff (reset)
		1'b1 |=> ext_fault == $past(d.motor_err)
	) else $error("external fault not following input");
	a_flush_lvl: assert property (
		@(posedge clk_sys) disable iff (reset)
		d.clear_pulse |=> pulse_flush
	) else $error("pulse flush missing");
	a_trim_gate: assert property (
		@(posedge clk_sys) disable iff (reset)
		!ctrl_q[C_PULSEMD] |=> !trim_pos_step && !trim_neg_step
	) else $error("trim outside pulse mode");
	a_trim_pos: assert property (
		@(posedge clk_sys) disable iff (reset)
		d.trim_pos && ctrl_q[C_PULSEMD] |=> trim_pos_step
	) else $error("positive trim missing");
	a_trim_neg: assert property (
		@(posedge clk_sys) disable iff (reset)
		d.trim_neg && ctrl_q[C_PULSEMD] |=> trim_neg_step
	) else $error("negative trim missing");
	a_target_sel: assert property (
		@(posedge clk_sys) disable iff (reset)
		ctrl_q[C_DINMODE] |=> target_idx == $past(d.pos_idx)
	) else $error("target index wrong");
	a_limit_blk: assert property (
		@(posedge clk_sys) disable iff (reset)
		!d.lim_pos |=> block_pos
	) else $error("positive limit not blocking");
	a_limit_neg: assert property (
		@(posedge clk_sys) disable iff (reset)
		!d.lim_neg |=> block_neg
	) else $error("negative limit not blocking");
endmodule // sifm_mapper
`default_nettype wire

// ===== hw/sifm_pkg.sv
// What this block does
// - quick-stop input clears control word bit 2 for emergency stop
// - with enable input, a fresh enable activation re-enables after stop; so does writing 0x06 then 0x0f
// - homing-start input starts origin search only while drive is enabled
// - when origin found, restore operating mode active before homing
// - command-activate input triggers like control word 0x2f to 0x3f
// - gear index bits 0..2 come from multi-function inputs 0..2
// - two-bit gain-table pointer from gain-switch inputs 0 and 1
// - motor-error input registers an external fault while asserted
// - each capture channel samples actual position on selected edge
// - capture responds to an input edge within 2 ms
// - rising edge on capture input 1 sets flag and stores position
// - falling edge on capture input 1 sets flag and stores position
// - while a capture flag is set, no further capture on that edge
// - capture channel 2 behaves like channel 1 with its own state
// - pre-enable 1 permits enabling, 0 refuses it
// - clear-pulse input discards received but unexecuted pulse data
// - pause input sets control word bit 8; release resumes commands
// - positive-trim input corrects position positively in pulse mode
// - negative-trim input corrects position negatively in pulse mode
// - position-index inputs select stored target entry in input mode
// - enable 1 gives configured control word, 0 forces 0x06
// - error-reset input sets control word bit 7
// - limit inputs are normally closed; 0 blocks that direction
`default_nettype none
package sifm_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned CAP_RESP_US   = 2000;
	localparam int unsigned CAP_RESP_CYC  =
		CAP_RESP_US * (CLK_HZ / 1_000_000);
	localparam int unsigned POS_W         = 32;
	localparam int unsigned CW_W          = 16;
	localparam int unsigned NCAP          = 2;
	// register word indexes
	localparam logic [3:0] A_CTRL    = 4'h0;
	localparam logic [3:0] A_STATUS  = 4'h1;
	localparam logic [3:0] A_CAPFLG  = 4'h2;
	localparam logic [3:0] A_EN_CW   = 4'h3;
	localparam logic [3:0] A_MODE    = 4'h4;
	localparam logic [3:0] A_CW      = 4'h5;
	localparam logic [3:0] A_CAP0    = 4'h8;
	// control word bits and values
	localparam int unsigned CW_QSTOP  = 2;
	localparam int unsigned CW_RSTERR = 7;
	localparam int unsigned CW_HALT   = 8;
	localparam logic [15:0] CW_SHUT   = 16'h0006;
	localparam logic [15:0] CW_OPER   = 16'h000f;
	localparam logic [15:0] CW_ARM    = 16'h002f;
	localparam logic [15:0] CW_GO     = 16'h003f;
	localparam logic [7:0]  MODE_HOME = 8'h06;
	localparam logic [7:0]  MODE_RST  = 8'h01;
	// ctrl register fields
	localparam int unsigned C_DINMODE = 0;
	localparam int unsigned C_PULSEMD = 1;
	localparam int unsigned C_CAPRISE = 2;
	localparam int unsigned C_CAPFALL = 4;

	typedef struct packed {
		logic enable;
		logic pre_enable;
		logic quick_stop_n;
		logic err_reset;
		logic start_home;
		logic home_found;
		logic activate;
		logic pause;
		logic motor_err;
		logic clear_pulse;
		logic trim_pos;
		logic trim_neg;
		logic lim_pos;
		logic lim_neg;
		logic [2:0] multi;
		logic [1:0] gain;
		logic [2:0] pos_idx;
		logic [1:0] cap;
	} sifm_din_t;
	localparam int unsigned DIN_W = $bits(sifm_din_t);
	// contact levels of an untouched input set
	localparam sifm_din_t DIN_IDLE = '{
		quick_stop_n: 1'b1, lim_pos: 1'b1, lim_neg: 1'b1, default: '0};
endpackage : sifm_pkg
`default_nettype wire

// ===== bench/sifm_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module sifm_switch_model
	import sifm_pkg::*;
(
	// clock
	input  wire logic      clk_sys,
	// levels the bench asks for
	input  wire sifm_din_t want,
	// contacts as the drive sees them
	output var  sifm_din_t din
);
	// contacts move one edge after the request, never mid-cycle
	initial din = '0;
	always @(posedge clk_sys) begin
		din <= want;
	end
endmodule // sifm_switch_model
`default_nettype wire

// ===== bench/sifm_mapper_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sifm_mapper_tb
	import sifm_pkg::*;
;
	logic             clk_sys;
	logic             reset;
	sifm_din_t        want;
	sifm_din_t        din;
	sifm_din_t        lv;
	logic [POS_W-1:0] act_pos;
	logic [POS_W-1:0] pv;
	logic [3:0]       reg_addr;
	logic [31:0]      reg_wdata;
	logic [31:0]      reg_rdata;
	logic [31:0]      rv;
	logic             reg_wr;
	logic             reg_rd;
	logic [CW_W-1:0]  ctrl_word;
	logic [7:0]       op_mode;
	logic             drive_enabled, cmd_trigger, ext_fault, pulse_flush;
	logic             trim_pos_step, trim_neg_step, block_pos, block_neg;
	logic [2:0]       gear_idx;
	logic [1:0]       gain_ptr;
	logic [2:0]       target_idx;
	int               num_errors = 0;
	int               comparisons = 0;

	sifm_switch_model sw (.clk_sys(clk_sys), .want(want), .din(din));
	sifm_mapper dut (
		.clk_sys(clk_sys), .reset(reset), .din(din), .act_pos(act_pos),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_word(ctrl_word),
		.op_mode(op_mode), .drive_enabled(drive_enabled),
		.cmd_trigger(cmd_trigger), .ext_fault(ext_fault),
		.pulse_flush(pulse_flush), .trim_pos_step(trim_pos_step),
		.trim_neg_step(trim_neg_step), .block_pos(block_pos),
		.block_neg(block_neg), .gear_idx(gear_idx), .gain_ptr(gain_ptr),
		.target_idx(target_idx));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// switch model edge + two sync stages + output register, plus margin
	task automatic put;
		@(posedge clk_sys);
		want <= lv;
		act_pos <= pv;
		repeat (5) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp,
		input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata);
	endtask
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_enable;
		lv.pre_enable = 1'b1;
		lv.enable = 1'b1;
		put();
		chk("cw enabled", 32'h000f, ctrl_word);
		chk("enabled", 1, drive_enabled);
		lv.pre_enable = 1'b0;
		put();
		chk("cw not ready", 32'h0006, ctrl_word);
		chk("refused", 0, drive_enabled);
		lv.pre_enable = 1'b1;
		put();
	endtask
	task automatic t_qstop;
		lv.quick_stop_n = 1'b0;
		put();
		chk("cw bit2", 0, ctrl_word[CW_QSTOP]);
		lv.quick_stop_n = 1'b1;
		put();
		chk("still stopped", 0, drive_enabled);
		lv.enable = 1'b0;
		put();
		lv.enable = 1'b1;
		put();
		chk("enable reopen", 1, drive_enabled);
		lv.quick_stop_n = 1'b0;
		put();
		lv.quick_stop_n = 1'b1;
		put();
		wr(A_CW, {16'h0, CW_SHUT});
		wr(A_CW, {16'h0, CW_OPER});
		lv.err_reset = 1'b0;
		put();
		chk("cw reopen", 1, drive_enabled);
		chk("cw bit2 back", 1, ctrl_word[CW_QSTOP]);
	endtask
	task automatic t_bits;
		lv.err_reset = 1'b1;
		put();
		chk("cw bit7", 1, ctrl_word[CW_RSTERR]);
		lv.err_reset = 1'b0;
		lv.pause = 1'b1;
		put();
		chk("cw bit8", 1, ctrl_word[CW_HALT]);
		lv.pause = 1'b0;
		put();
		chk("cw bit8 off", 0, ctrl_word[CW_HALT]);
	endtask
	task automatic t_home;
		wr(A_MODE, 32'h0000_0003);
		lv.start_home = 1'b1;
		put();
		chk("homing", MODE_HOME, op_mode);
		lv.start_home = 1'b0;
		lv.home_found = 1'b1;
		put();
		chk("mode back", 32'h0003, op_mode);
		lv.home_found = 1'b0;
		lv.enable = 1'b0;
		put();
		lv.start_home = 1'b1;
		put();
		chk("home ignored", 32'h0003, op_mode);
		lv.start_home = 1'b0;
		lv.enable = 1'b1;
		put();
	endtask
	task automatic t_activate;
		int n;
		logic [5:0] cw;
		n = 0;
		cw = 6'h00;
		lv.activate = 1'b1;
		@(posedge clk_sys);
		want <= lv;
		repeat (8) begin
			@(posedge clk_sys);
			#1;
			if (cmd_trigger === 1'b1) begin
				n++;
				cw = ctrl_word[5:0];
			end
		end
		chk("trigger count", 1, n);
		chk("trigger cw", CW_GO, cw);
		lv.activate = 1'b0;
		put();
	endtask
	task automatic t_index;
		wr(A_CTRL, 32'h0000_003f);
		for (int i = 0; i < 8; i++) begin
			lv.multi = i[2:0];
			lv.gain = i[1:0];
			lv.pos_idx = ~i[2:0];
			put();
			chk("gear", i, gear_idx);
			chk("gain", i & 3, gain_ptr);
			chk("target", 7 - i, target_idx);
		end
	endtask
	task automatic t_misc;
		lv.motor_err = 1'b1;
		lv.clear_pulse = 1'b1;
		lv.lim_pos = 1'b0;
		put();
		chk("fault", 1, ext_fault);
		chk("flush", 1, pulse_flush);
		chk("block pos", 2'b10, {block_pos, block_neg});
		lv.motor_err = 1'b0;
		lv.clear_pulse = 1'b0;
		lv.lim_pos = 1'b1;
		wr(A_CTRL, 32'h0000_003d);
		lv.trim_pos = 1'b1;
		put();
		chk("trim gated", 0, trim_pos_step);
		chk("fault off", 0, ext_fault);
		wr(A_CTRL, 32'h0000_003f);
		put();
		chk("trim pos", 1, trim_pos_step);
		lv.trim_pos = 1'b0;
		lv.trim_neg = 1'b1;
		put();
		chk("trim neg", 2'b01, {trim_pos_step, trim_neg_step});
		lv.trim_neg = 1'b0;
	endtask
	task automatic t_capture;
		pv = 32'h1111_1111;
		lv.cap = 2'b01;
		put();
		rd(A_CAPFLG, 32'h1, "flag rise1");
		rd(A_CAP0, 32'h1111_1111, "pos rise1");
		pv = 32'h2222_2222;
		lv.cap = 2'b00;
		put();
		rd(A_CAPFLG, 32'h3, "flag fall1");
		rd(A_CAP0 + 4'h1, 32'h2222_2222, "pos fall1");
		pv = 32'h3333_3333;
		lv.cap = 2'b01;
		put();
		rd(A_CAP0, 32'h1111_1111, "pos held");
		wr(A_CAPFLG, 32'h0000_000e);
		rd(A_CAPFLG, 32'h2, "flag cleared");
		lv.cap = 2'b00;
		put();
		pv = 32'h4444_4444;
		lv.cap = 2'b01;
		put();
		rd(A_CAP0, 32'h4444_4444, "pos again");
		pv = 32'h5555_5555;
		lv.cap = 2'b11;
		put();
		rd(A_CAPFLG, 32'h7, "flag rise2");
		rd(A_CAP0 + 4'h2, 32'h5555_5555, "pos rise2");
		rd(4'hf, 32'h0, "unmapped");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		lv = '0;
		lv.quick_stop_n = 1'b1;
		lv.lim_pos = 1'b1;
		lv.lim_neg = 1'b1;
		want = lv;
		act_pos = '0;
		pv = '0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("reset cw", 32'h0006, ctrl_word);
		chk("reset mode", MODE_RST, op_mode);
		@(posedge clk_sys);
		reset <= 1'b0;
		put();
		chk("limits open", 2'b00, {block_pos, block_neg});
		t_enable();
		t_qstop();
		t_bits();
		t_home();
		t_activate();
		t_index();
		t_misc();
		t_capture();
		conclude();
	end
endmodule // sifm_mapper_tb
`default_nettype wire
